/* hdl/buck_fault_protection_sequencer.sv */
`timescale 1ns/1ns
// What this block does
// [R1] After first enable past lockout, run threshold capture for 5.5 to 6.5 ms.
// [R2] Keep programming level divided by three as threshold until supply recycles.
// [R3] Capture phase length grows in proportion to the captured threshold.
// [R4] Captured threshold spans 50 mV to 500 mV.
// [R5] With no programming resistor, take the maximum threshold.
// [R6] Above the high-supply level, threshold becomes a fixed 400 mV.
// [R7] Feedback undervoltage turns both gates off, waits 2048 cycles, restarts.
// [R8] Persistent undervoltage repeats shutdown and restart, a hiccup near 5.2 ms.
// [R9] Undervoltage is ignored during soft-start and armed once it ends.
// [R10] Overvoltage forces high side off and low side on, over the modulator.
// [R11] Overvoltage acts always after capture and beats every other gate request.
// [R12] Feedback bias is always sourced so a floating input reads overvoltage.
// [R13] Leave lockout above the upper supply level, shut down below the lower.
// [R14] Modulator compares error amplifier level with the oscillator ramp.
// [R15] Soft-start starts only with supply good and capture complete.
// [R16] Two consecutive cycles of overcurrent: gates off 2048 plus residual cycles.
// [R17] Soft-start ramps the reference from 0 to 0.8 V in about 5.1 ms.
// [R18] Comparator inputs are synchronised before driving protection decisions.
// [R19] Restart wait counter clears on shutdown entry; lockout resets the sequencer state and the capture flag.
module buck_fault_protection_sequencer #(
  parameter int CAP_MIN_CYCLES = buck_seq_pkg::CAP_MIN_CYC,
  parameter int CAP_MAX_CYCLES = buck_seq_pkg::CAP_MAX_CYC,
  parameter int SS_STEP_CYCLES = buck_seq_pkg::SS_STEP_CYC,
  parameter int RESTART_CYCLES = buck_seq_pkg::RESTART_CYC,
  parameter int RAMP_CYCLES = buck_seq_pkg::RAMP_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Comparator and enable levels
  input wire logic enable_in,
  input wire logic supply_above_upper,
  input wire logic supply_below_lower,
  input wire logic high_supply_detect_level,
  input wire logic feedback_below_uv,
  input wire logic feedback_above_ov,
  input wire logic overcurrent_event,
  // Analog measurements as codes
  input wire logic [buck_seq_pkg::CODE_W-1:0] prog_level_mv,
  input wire logic prog_open,
  input wire logic [buck_seq_pkg::RAMP_W-1:0] error_amp_level,
  // Gate drive and status
  output logic high_side_gate,
  output logic low_side_gate,
  output logic soft_start_trigger,
  output logic [buck_seq_pkg::MV_W-1:0] soft_start_ref_mv,
  output logic [buck_seq_pkg::MV_W-1:0] overcurrent_threshold_mv,
  output logic overcurrent_threshold_capture,
  output logic fault_shutdown,
  output logic feedback_bias_on
);
  localparam int CAP_SLOPE = (CAP_MAX_CYCLES - CAP_MIN_CYCLES) / buck_seq_pkg::THR_MAX_MV;
  localparam int CW = buck_seq_pkg::CNT_W;
  localparam int MW = buck_seq_pkg::MV_W;
  localparam int RW = buck_seq_pkg::RAMP_W;

  logic [buck_seq_pkg::SYN_W-1:0] sync1_reg, sync2_reg;
  logic en_s, high_s, uv_s, ov_s, oc_s;
  logic supply_ok_reg;
  buck_seq_pkg::seq_state_type state_reg, state_next;
  logic [CW-1:0] cap_cnt_reg, cap_len_reg, wait_cnt_reg, wait_len_reg;
  logic [MW-1:0] thr_reg, thr_sample, ref_reg;
  localparam int CODE_W_LOC = buck_seq_pkg::CODE_W;
  logic [CODE_W_LOC-1:0] prog_div;
  logic captured_reg;
  logic [CW-1:0] step_cnt_reg, resid_full, resid;
  logic [RW-1:0] ramp_cnt_reg;
  logic pwm, cycle_end, cap_done, wait_done, oc_trip;
  logic oc_this_reg, oc_prev_reg, low_seen_ok_reg;
  logic high_reg, low_reg, high_next, low_next, trig_reg, shut_reg, bias_reg;
  logic [MW-1:0] thr_out_reg;
  logic cap_busy_reg;
  logic [CW-1:0] busy_len, sd_len;

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {overcurrent_event, feedback_above_ov, feedback_below_uv, // [R18]
                    high_supply_detect_level, supply_below_lower, supply_above_upper, enable_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign en_s = sync2_reg[buck_seq_pkg::SYN_EN];
  assign high_s = sync2_reg[buck_seq_pkg::SYN_HIGH];
  assign uv_s = sync2_reg[buck_seq_pkg::SYN_UV];
  assign ov_s = sync2_reg[buck_seq_pkg::SYN_OV];
  assign oc_s = sync2_reg[buck_seq_pkg::SYN_OC];

  // Supply lockout with hysteresis between the two comparator levels
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      supply_ok_reg <= 1'h0;
    else if (sync2_reg[buck_seq_pkg::SYN_UPPER])
      supply_ok_reg <= 1'h1; // [R13]
    else if (sync2_reg[buck_seq_pkg::SYN_LOWER])
      supply_ok_reg <= 1'h0; // [R13]
  end

  // Oscillator ramp; the modulator output is a plain compare against it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ramp_cnt_reg <= '0;
    else if (cycle_end)
      ramp_cnt_reg <= '0;
    else
      ramp_cnt_reg <= ramp_cnt_reg + RW'(1);
  end

  assign cycle_end = (ramp_cnt_reg == RW'(RAMP_CYCLES - 1));
  assign pwm = (error_amp_level > ramp_cnt_reg); // [R14]

  // Threshold sample: open input gives maximum, else level over three, clamped
  always_comb
  begin
    prog_div = prog_level_mv / CODE_W_LOC'(buck_seq_pkg::PROG_DIVIDE); // [R2]
    if (prog_open)
      thr_sample = MW'(buck_seq_pkg::THR_MAX_MV); // [R5]
    else if (prog_div > CODE_W_LOC'(buck_seq_pkg::THR_MAX_MV))
      thr_sample = MW'(buck_seq_pkg::THR_MAX_MV); // [R4]
    else if (prog_div < CODE_W_LOC'(buck_seq_pkg::THR_MIN_MV))
      thr_sample = MW'(buck_seq_pkg::THR_MIN_MV); // [R4]
    else
      thr_sample = MW'(prog_div);
  end

  assign cap_done = (cap_cnt_reg >= cap_len_reg - CW'(1));
  assign wait_done = (wait_cnt_reg >= wait_len_reg - CW'(1));
  assign oc_trip = cycle_end && oc_prev_reg && (oc_this_reg || (oc_s && low_reg)); // [R16]

  // Residual soft-start time, capped at one restart interval
  always_comb
  begin
    resid_full = CW'(buck_seq_pkg::REF_FINAL_MV - int'(ref_reg)) * CW'(SS_STEP_CYCLES);
    resid = (resid_full > CW'(RESTART_CYCLES)) ? CW'(RESTART_CYCLES) : resid_full;
  end

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      buck_seq_pkg::SEQ_OFF:
        if (en_s)
          state_next = captured_reg ? buck_seq_pkg::SEQ_SOFTSTART // [R15]
                                    : buck_seq_pkg::SEQ_CAPTURE; // [R1]
      buck_seq_pkg::SEQ_CAPTURE:
        if (cap_done)
          state_next = en_s ? buck_seq_pkg::SEQ_SOFTSTART : buck_seq_pkg::SEQ_OFF; // [R15]
      buck_seq_pkg::SEQ_SOFTSTART:
        if (!en_s)
          state_next = buck_seq_pkg::SEQ_OFF;
        else if (oc_trip)
          state_next = buck_seq_pkg::SEQ_SHUTDOWN; // [R16]
        else if (ref_reg == MW'(buck_seq_pkg::REF_FINAL_MV))
          state_next = buck_seq_pkg::SEQ_RUN; // [R9]
      buck_seq_pkg::SEQ_RUN:
        if (!en_s)
          state_next = buck_seq_pkg::SEQ_OFF;
        else if (oc_trip || uv_s)
          state_next = buck_seq_pkg::SEQ_SHUTDOWN; // [R7]
      buck_seq_pkg::SEQ_SHUTDOWN:
        if (!en_s)
          state_next = buck_seq_pkg::SEQ_OFF;
        else if (wait_done)
          state_next = buck_seq_pkg::SEQ_SOFTSTART; // [R8]
      default:
        state_next = buck_seq_pkg::SEQ_OFF;
    endcase
  end

  // State register; lockout forces the state back to off
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= buck_seq_pkg::SEQ_OFF;
    else if (!supply_ok_reg)
      state_reg <= buck_seq_pkg::SEQ_OFF; // [R19]
    else
      state_reg <= state_next;
  end

  // Threshold capture: length set from the sample taken on entry
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      captured_reg <= 1'h0;
      thr_reg <= '0;
      cap_len_reg <= '0;
      cap_cnt_reg <= '0;
    end
    else if (!supply_ok_reg)
      captured_reg <= 1'h0; // [R2]
    else if (state_reg == buck_seq_pkg::SEQ_OFF && state_next == buck_seq_pkg::SEQ_CAPTURE)
    begin
      thr_reg <= thr_sample; // [R2]
      cap_len_reg <= CW'(CAP_MIN_CYCLES) + CW'(thr_sample) * CW'(CAP_SLOPE); // [R3]
      cap_cnt_reg <= '0;
    end
    else if (state_reg == buck_seq_pkg::SEQ_CAPTURE)
    begin
      cap_cnt_reg <= cap_cnt_reg + CW'(1); // [R1]
      if (cap_done)
        captured_reg <= 1'h1;
    end
  end

  // Soft-start reference ramp, one millivolt per step period
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_reg <= '0;
      step_cnt_reg <= '0;
    end
    else if (state_reg == buck_seq_pkg::SEQ_SOFTSTART)
    begin
      if (step_cnt_reg == CW'(SS_STEP_CYCLES - 1))
      begin
        step_cnt_reg <= '0;
        if (ref_reg != MW'(buck_seq_pkg::REF_FINAL_MV))
          ref_reg <= ref_reg + MW'(1); // [R17]
      end
      else
        step_cnt_reg <= step_cnt_reg + CW'(1);
    end
    else if (state_reg != buck_seq_pkg::SEQ_RUN)
    begin
      ref_reg <= '0;
      step_cnt_reg <= '0;
    end
  end

  // Overcurrent history per switching cycle; an event on the last clock counts for the ending cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_this_reg <= 1'h0;
      oc_prev_reg <= 1'h0;
    end
    else if (state_reg != buck_seq_pkg::SEQ_SOFTSTART && state_reg != buck_seq_pkg::SEQ_RUN)
    begin
      oc_this_reg <= 1'h0;
      oc_prev_reg <= 1'h0;
    end
    else if (cycle_end)
    begin
      oc_prev_reg <= oc_this_reg || (oc_s && low_reg); // [R16]
      oc_this_reg <= 1'h0;
    end
    else if (oc_s && low_reg)
      oc_this_reg <= 1'h1;
  end

  // Restart wait, cleared on entry; residual ramp time added for a trip during soft-start
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_cnt_reg <= '0;
      wait_len_reg <= '0;
    end
    else if (state_next == buck_seq_pkg::SEQ_SHUTDOWN &&
             state_reg != buck_seq_pkg::SEQ_SHUTDOWN)
    begin
      wait_cnt_reg <= '0; // [R19]
      wait_len_reg <= CW'(RESTART_CYCLES) +
        ((state_reg == buck_seq_pkg::SEQ_SOFTSTART) ? resid : '0); // [R16]
    end
    else if (state_reg == buck_seq_pkg::SEQ_SHUTDOWN)
      wait_cnt_reg <= wait_cnt_reg + CW'(1); // [R7]
  end

  // Gate request with overvoltage on top; low side held off in soft-start until
  // the high side has switched, so a pre-biased output is not pulled down
  always_comb
  begin
    high_next = 1'h0;
    low_next = 1'h0;
    if (!supply_ok_reg)
    begin
      high_next = 1'h0;
      low_next = 1'h0;
    end
    else if (captured_reg && ov_s)
    begin
      high_next = 1'h0; // [R10]
      low_next = 1'h1; // [R11]
    end
    else if (state_next == buck_seq_pkg::SEQ_RUN)
    begin
      high_next = pwm;
      low_next = !pwm;
    end
    else if (state_next == buck_seq_pkg::SEQ_SOFTSTART)
    begin
      high_next = pwm;
      low_next = !pwm && low_seen_ok_reg;
    end
  end

  // Outputs and low-side release flag, all registered
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_reg <= 1'h0;
      low_reg <= 1'h0;
      trig_reg <= 1'h0;
      shut_reg <= 1'h0;
      cap_busy_reg <= 1'h0;
      thr_out_reg <= '0;
      low_seen_ok_reg <= 1'h0;
      bias_reg <= 1'h1;
    end
    else
    begin
      high_reg <= high_next;
      low_reg <= low_next;
      trig_reg <= supply_ok_reg && state_reg != buck_seq_pkg::SEQ_SOFTSTART &&
                  state_next == buck_seq_pkg::SEQ_SOFTSTART;
      shut_reg <= supply_ok_reg && state_next == buck_seq_pkg::SEQ_SHUTDOWN;
      cap_busy_reg <= supply_ok_reg && state_next == buck_seq_pkg::SEQ_CAPTURE;
      thr_out_reg <= high_s ? MW'(buck_seq_pkg::THR_HIGH_SUPPLY_MV) : thr_reg; // [R6]
      low_seen_ok_reg <= (state_reg == buck_seq_pkg::SEQ_SOFTSTART) &&
                         (low_seen_ok_reg || high_reg);
      bias_reg <= 1'h1; // [R12]
    end
  end

  assign high_side_gate = high_reg;
  assign low_side_gate = low_reg;
  assign soft_start_trigger = trig_reg;
  assign soft_start_ref_mv = ref_reg;
  assign overcurrent_threshold_mv = thr_out_reg;
  assign overcurrent_threshold_capture = cap_busy_reg;
  assign fault_shutdown = shut_reg;
  assign feedback_bias_on = bias_reg;

  // Helper lengths for the checks below
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_len <= '0;
      sd_len <= '0;
    end
    else
    begin
      busy_len <= cap_busy_reg ? busy_len + CW'(1) : '0;
      sd_len <= shut_reg ? sd_len + CW'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_CAPTURE_WINDOW: assert property ( // [R1]
    $fell(cap_busy_reg) && captured_reg |->
      busy_len >= CW'(CAP_MIN_CYCLES) && busy_len <= CW'(CAP_MAX_CYCLES))
    else $error("capture phase length outside window");
  AST_CAPTURE_SCALE: assert property ( // [R3]
    $fell(cap_busy_reg) && captured_reg |->
      busy_len == CW'(CAP_MIN_CYCLES) + CW'(thr_reg) * CW'(CAP_SLOPE))
    else $error("capture length not proportional to threshold");
  AST_THRESHOLD_HELD: assert property ( // [R2]
    captured_reg && $past(captured_reg) |-> $stable(thr_reg))
    else $error("captured threshold changed");
  AST_THRESHOLD_RANGE: assert property ( // [R4]
    captured_reg |-> thr_reg >= MW'(buck_seq_pkg::THR_MIN_MV) &&
      thr_reg <= MW'(buck_seq_pkg::THR_MAX_MV))
    else $error("threshold out of range");
  AST_HIGH_SUPPLY: assert property ( // [R6]
    high_s |=> overcurrent_threshold_mv == MW'(buck_seq_pkg::THR_HIGH_SUPPLY_MV))
    else $error("high supply threshold not applied");
  AST_OV_OVERRIDE: assert property ( // [R10]
    supply_ok_reg && captured_reg && ov_s |=> !high_side_gate && low_side_gate)
    else $error("overvoltage did not override gates");
  AST_UV_SHUTDOWN: assert property ( // [R7]
    state_reg == buck_seq_pkg::SEQ_RUN && uv_s && en_s && supply_ok_reg && !ov_s
      |=> fault_shutdown && !high_side_gate && !low_side_gate)
    else $error("undervoltage did not shut gates");
  AST_UV_MASKED: assert property ( // [R9]
    state_reg == buck_seq_pkg::SEQ_SOFTSTART && !oc_trip |=>
      state_reg != buck_seq_pkg::SEQ_SHUTDOWN)
    else $error("undervoltage acted during soft-start");
  AST_RESTART_WAIT: assert property ( // [R16]
    $fell(fault_shutdown) && state_reg == buck_seq_pkg::SEQ_SOFTSTART |->
      sd_len >= CW'(RESTART_CYCLES) && sd_len <= CW'(2 * RESTART_CYCLES))
    else $error("restart wait length wrong");
  AST_SS_NEEDS_CAPTURE: assert property ( // [R15]
    soft_start_trigger |-> captured_reg && supply_ok_reg)
    else $error("soft-start before capture");
  AST_LOCKOUT: assert property ( // [R13]
    !supply_ok_reg |=> state_reg == buck_seq_pkg::SEQ_OFF && !high_side_gate && !low_side_gate)
    else $error("lockout did not stop the block");
endmodule

/* hdl/buck_seq_pkg.sv */
package buck_seq_pkg;
  // Clock and derived timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAP_MIN_NS = 5_500_000;
  localparam int CAP_MAX_NS = 6_500_000;
  localparam int CAP_MIN_CYC = (CAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAP_MAX_CYC = CAP_MAX_NS / CLK_PERIOD_NS;
  localparam int SS_TIME_NS = 5_100_000;
  localparam int SS_CYC = SS_TIME_NS / CLK_PERIOD_NS;
  localparam int RAMP_PERIOD_NS = 3_333;
  localparam int RAMP_CYC = RAMP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RESTART_CYC = 2048;
  // Levels in millivolts
  localparam int REF_FINAL_MV = 800;
  localparam int SS_STEP_CYC = SS_CYC / REF_FINAL_MV;
  localparam int THR_MIN_MV = 50;
  localparam int THR_MAX_MV = 500;
  localparam int THR_HIGH_SUPPLY_MV = 400;
  localparam int PROG_DIVIDE = 3;
  // Widths
  localparam int MV_W = 10;
  localparam int CODE_W = 11;
  localparam int RAMP_W = 7;
  localparam int CNT_W = 18;
  // Synchroniser bit positions
  localparam int SYN_EN = 0;
  localparam int SYN_UPPER = 1;
  localparam int SYN_LOWER = 2;
  localparam int SYN_HIGH = 3;
  localparam int SYN_UV = 4;
  localparam int SYN_OV = 5;
  localparam int SYN_OC = 6;
  localparam int SYN_W = 7;
  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF = 3'h0,
    SEQ_CAPTURE = 3'h1,
    SEQ_SOFTSTART = 3'h2,
    SEQ_RUN = 3'h3,
    SEQ_SHUTDOWN = 3'h4
  } seq_state_type;
endpackage

/* sim/buck_gate_partner.sv */
`timescale 1ns/1ns
// Far side: power stage sense and feedback comparators
module buck_gate_partner (
  // Gate drive seen from the device
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic feedback_bias_on,
  // Scenario controls
  input wire logic oc_load,
  input wire logic fb_float,
  input wire logic ov_force,
  // Comparator outputs
  output logic overcurrent_event,
  output logic feedback_above_ov
);
  // Drop across the low side only exists while that switch conducts
  assign overcurrent_event = oc_load & low_side_gate;
  // A floating feedback node is pulled over the limit by the bias source
  assign feedback_above_ov = ov_force | (fb_float & feedback_bias_on);
endmodule

/* sim/test_buck_fault_protection_sequencer.sv */
`timescale 1ns/1ns
module test_buck_fault_protection_sequencer;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0, up = 1'b0, lo = 1'b1, hi_sup = 1'b0, uv = 1'b0;
  logic ov_force = 1'b0, fb_float = 1'b0, oc_load = 1'b0, popen = 1'b0;
  logic [buck_seq_pkg::CODE_W-1:0] prog = 11'h000;
  logic [buck_seq_pkg::RAMP_W-1:0] ea = 7'h1E;
  logic hs, ls, trig, cap, flt, bias, oc_ev, ov;
  logic [buck_seq_pkg::MV_W-1:0] ref_mv, thr;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  // Shortened counts keep the run small; expectations derive from these
  localparam int CMIN = 100;
  localparam int CMAX = 600;
  localparam int RST = 16;

  buck_fault_protection_sequencer #(.CAP_MIN_CYCLES(CMIN), .CAP_MAX_CYCLES(CMAX),
    .SS_STEP_CYCLES(1), .RESTART_CYCLES(RST), .RAMP_CYCLES(66))
  buck_fault_protection_sequencer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .enable_in(en),
    .supply_above_upper(up), .supply_below_lower(lo), .high_supply_detect_level(hi_sup),
    .feedback_below_uv(uv), .feedback_above_ov(ov), .overcurrent_event(oc_ev),
    .prog_level_mv(prog), .prog_open(popen), .error_amp_level(ea), .high_side_gate(hs),
    .low_side_gate(ls), .soft_start_trigger(trig), .soft_start_ref_mv(ref_mv),
    .overcurrent_threshold_mv(thr), .overcurrent_threshold_capture(cap),
    .fault_shutdown(flt), .feedback_bias_on(bias));

  buck_gate_partner buck_gate_partner_inst (.high_side_gate(hs), .low_side_gate(ls),
    .feedback_bias_on(bias), .oc_load(oc_load), .fb_float(fb_float), .ov_force(ov_force),
    .overcurrent_event(oc_ev), .feedback_above_ov(ov));

  // Clock at 20 MHz
  always #25 clk_sys = ~clk_sys;

  // Hang guard: far above the sum of all scenario lengths
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      summarize();
    end
  end

  task summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always move 5 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  // Soft-start to full reference; undervoltage held at uv_early until near the end
  task t_softstart(input logic uv_early);
    int n;
    int bad;
    bad = 0;
    uv = uv_early;
    for (n = 0; n < 2000 && ref_mv < 10'h316; n++)
    begin
      step(1);
      if (flt !== 1'b0) bad++;
    end
    uv = 1'b0;
    for (n = 0; n < 100 && ref_mv !== 10'h320; n++) step(1);
    check(bad, 0);
    check(ref_mv, 10'h320);
    step(4);
  endtask

  // Capture after supply comes up; length grows one cycle per mV here
  task t_capture(input logic [10:0] p, input logic o, input int exp_thr);
    int n;
    int len;
    prog = p;
    popen = o;
    lo = 1'b0;
    up = 1'b1;
    step(4);
    en = 1'b1;
    for (n = 0; n < 20 && cap !== 1'b1; n++) step(1);
    for (len = 0; len < 1000 && cap === 1'b1; len++) step(1);
    check(len, CMIN + exp_thr * (CMAX - CMIN) / buck_seq_pkg::THR_MAX_MV);
    check(thr, exp_thr);
    for (n = 0; n < 5 && trig !== 1'b1; n++) step(1);
    check(trig, 1'b1);
    t_softstart(1'b1);
  endtask

  task t_modulator();
    int h;
    h = 0;
    repeat (66)
    begin
      step(1);
      if (hs === 1'b1) h++;
    end
    // High side is on exactly while the ramp sits below the error level
    check(h, ea);
  endtask

  task t_uv();
    int n;
    int len;
    int on;
    on = 0;
    uv = 1'b1;
    for (n = 0; n < 10 && flt !== 1'b1; n++) step(1);
    for (len = 0; len < 100 && flt === 1'b1; len++)
    begin
      if (hs !== 1'b0 || ls !== 1'b0) on++;
      step(1);
    end
    check(len, RST);
    check(on, 0);
    for (n = 0; n < 2000 && flt !== 1'b1; n++) step(1);
    check(flt, 1'b1);
    for (n = 0; n < 100 && flt === 1'b1; n++) step(1);
    t_softstart(1'b0);
  endtask

  // Driven overvoltage, then a floating feedback node
  task t_ov();
    int k;
    check(bias, 1'b1);
    for (k = 0; k < 2; k++)
    begin
      ov_force = (k == 0);
      fb_float = (k == 1);
      step(4);
      repeat (3)
      begin
        check({hs, ls}, 2'h1);
        step(1);
      end
      ov_force = 1'b0;
      fb_float = 1'b0;
      step(4);
    end
  endtask

  // Trip from run, then again early in the next soft-start, where the residual
  // ramp time is far beyond one restart interval and so is capped at it
  task t_oc();
    int n;
    int len;
    oc_load = 1'b1;
    for (n = 0; n < 400 && flt !== 1'b1; n++) step(1);
    check(flt, 1'b1);
    for (len = 0; len < 200 && flt === 1'b1; len++) step(1);
    check(len, RST);
    for (n = 0; n < 400 && flt !== 1'b1; n++) step(1);
    oc_load = 1'b0;
    for (len = 0; len < 200 && flt === 1'b1; len++) step(1);
    check(len, 2 * RST);
    t_softstart(1'b0);
  endtask

  task t_high(input int kept);
    hi_sup = 1'b1;
    step(5);
    check(thr, buck_seq_pkg::THR_HIGH_SUPPLY_MV);
    hi_sup = 1'b0;
    step(5);
    check(thr, kept);
  endtask

  task t_lockout();
    up = 1'b0;
    lo = 1'b1;
    en = 1'b0;
    step(5);
    check({hs, ls, cap}, 3'h0);
  endtask

  initial
  begin
    step(3);
    rst_n = 1'b1;
    t_capture(11'h12C, 1'b0, 100);
    t_modulator();
    t_uv();
    t_ov();
    t_oc();
    t_high(100);
    t_lockout();
    t_capture(11'h000, 1'b1, 500);
    t_high(500);
    summarize();
  end
endmodule
